// ==== hdl/arpc_top.sv ====
// arpc_top: result registers with offset correction, limit checks and
// the converter power manager of a dual cyclic converter back end.
// assumes the converter cores report each finished sample on a done
// pulse with its slot and raw code, and hold busy for a whole scan.
`timescale 1ns/10ps
module arpc_top (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [23:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // converter cores: scan requests and scan activity
    input wire logic scan_req_a_in,
    input wire logic scan_req_b_in,
    input wire logic scan_busy_a_in,
    input wire logic scan_busy_b_in,
    // converter cores: finished samples
    input wire logic done_a_in,
    input wire logic [2:0] slot_a_in,
    input wire logic [11:0] raw_a_in,
    input wire logic done_b_in,
    input wire logic [2:0] slot_b_in,
    input wire logic [11:0] raw_b_in,
    // power and clock controls toward the analog side
    output logic scan_grant_a_out,
    output logic scan_grant_b_out,
    output logic conv_a_power_out,
    output logic conv_b_power_out,
    output logic ref_power_out,
    output logic standby_current_out,
    output logic standby_clk_sel_out,
    output logic upper_ref_source_out,
    output logic lower_ref_source_out,
    // sticky flags toward the rest of the converter
    output logic [7:0] sample_ready_flag_out,
    output logic [7:0] high_exceed_flag_out,
    output logic [7:0] low_exceed_flag_out
);
    // stored value of raw minus offset: sign, then 12-bit two's complement
    function automatic logic [15:0] correct(input logic [11:0] raw,
                                            input logic [11:0] ofs);
        logic [12:0] diff;
        diff = {1'b0, raw} - {1'b0, ofs};
        correct = {diff[12], diff[11:0], 3'h0};
    endfunction

    // true if addr falls in an eight-register bank at base
    function automatic logic hit(input logic [23:0] addr,
                                 input logic [23:0] base);
        logic [23:0] rel;
        rel = addr - base;
        hit = (rel < 24'h000010) && !rel[0];
    endfunction

    function automatic logic [2:0] slot_of(input logic [23:0] addr,
                                           input logic [23:0] base);
        logic [23:0] rel;
        rel = addr - base;
        slot_of = rel[3:1];
    endfunction

    logic [15:0] result_r [8];
    logic [11:0] low_r [8];
    logic [11:0] high_r [8];
    logic [11:0] offset_r [8];
    logic [7:0] ready_r;
    logic [7:0] high_flag_r;
    logic [7:0] low_flag_r;

    logic auto_standby_r;
    logic auto_pd_r;
    logic [5:0] dly_r;
    logic ref_force_r;
    logic force_a_r;
    logic force_b_r;
    logic upper_ref_r;
    logic lower_ref_r;

    arpc_pkg::arpc_pstate_t state_r;
    logic [5:0] wake_cnt_r;
    logic lp_pd_r;
    logic lp_sb_r;
    logic need_a_r;
    logic need_b_r;
    logic on_a_r;
    logic on_b_r;
    logic off_a_r;
    logic off_b_r;
    logic [5:0] stat_cnt_a_r;
    logic [5:0] stat_cnt_b_r;
    logic force_a_d_r;
    logic force_b_d_r;

    logic [15:0] power_word;
    logic [15:0] rdata_nxt;
    logic wr_res;
    logic wr_low;
    logic wr_high;
    logic wr_ofs;
    logic rd_res;
    logic [2:0] wslot;
    logic [2:0] rslot;
    logic [7:0] set_ready;
    logic [7:0] set_high;
    logic [7:0] set_low;
    logic [7:0] clr_ready;
    logic [7:0] clr_high;
    logic [7:0] clr_low;

    assign wr_res = reg_wr_in && hit(reg_addr_in, arpc_pkg::RESULT_BASE);
    assign wr_low = reg_wr_in && hit(reg_addr_in, arpc_pkg::LOW_BASE);
    assign wr_high = reg_wr_in && hit(reg_addr_in, arpc_pkg::HIGH_BASE);
    assign wr_ofs = reg_wr_in && hit(reg_addr_in, arpc_pkg::OFFSET_BASE);
    assign rd_res = reg_rd_in && hit(reg_addr_in, arpc_pkg::RESULT_BASE);
    assign wslot = slot_of(reg_addr_in, arpc_pkg::RESULT_BASE);
    assign rslot = wslot;

    // per-slot events from the converters
    always_comb begin
        set_ready = 8'h00;
        set_high = 8'h00;
        set_low = 8'h00;
        if (done_a_in) begin
            set_ready[slot_a_in] = 1'b1;
            set_high[slot_a_in] = raw_a_in > high_r[slot_a_in];
            set_low[slot_a_in] = raw_a_in < low_r[slot_a_in];
        end
        if (done_b_in) begin
            set_ready[slot_b_in] = 1'b1;
            set_high[slot_b_in] = raw_b_in > high_r[slot_b_in];
            set_low[slot_b_in] = raw_b_in < low_r[slot_b_in];
        end
    end

    always_comb begin
        clr_ready = 8'h00;
        clr_high = 8'h00;
        clr_low = 8'h00;
        if (rd_res) begin
            clr_ready[rslot] = 1'b1;
        end
        if (reg_wr_in && reg_addr_in == arpc_pkg::LIMIT_STAT_ADDR) begin
            clr_high = reg_wdata_in[15:8];
            clr_low = reg_wdata_in[7:0];
        end
    end

    // result registers; a converter store beats a software write
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < arpc_pkg::SLOTS; i++) begin
                result_r[i] <= arpc_pkg::RESULT_RESET;
            end
        end else begin
            if (wr_res) begin
                result_r[wslot] <= correct(
                    reg_wdata_in[arpc_pkg::VAL_MSB:arpc_pkg::VAL_LSB],
                    offset_r[wslot]);
            end
            if (done_a_in) begin
                result_r[slot_a_in] <= correct(raw_a_in,
                    offset_r[slot_a_in]);
            end
            if (done_b_in) begin
                result_r[slot_b_in] <= correct(raw_b_in,
                    offset_r[slot_b_in]);
            end
        end
    end

    // limit and offset registers
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < arpc_pkg::SLOTS; i++) begin
                low_r[i] <= arpc_pkg::LOW_RESET;
                high_r[i] <= arpc_pkg::HIGH_RESET;
                offset_r[i] <= arpc_pkg::OFFSET_RESET;
            end
        end else begin
            if (wr_low) begin
                low_r[slot_of(reg_addr_in, arpc_pkg::LOW_BASE)] <=
                    reg_wdata_in[arpc_pkg::VAL_MSB:arpc_pkg::VAL_LSB];
            end
            if (wr_high) begin
                high_r[slot_of(reg_addr_in, arpc_pkg::HIGH_BASE)] <=
                    reg_wdata_in[arpc_pkg::VAL_MSB:arpc_pkg::VAL_LSB];
            end
            if (wr_ofs) begin
                offset_r[slot_of(reg_addr_in, arpc_pkg::OFFSET_BASE)] <=
                    reg_wdata_in[arpc_pkg::VAL_MSB:arpc_pkg::VAL_LSB];
            end
        end
    end

    // sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ready_r <= 8'h00;
            high_flag_r <= 8'h00;
            low_flag_r <= 8'h00;
        end else begin
            ready_r <= (ready_r & ~clr_ready) | set_ready;
            high_flag_r <= (high_flag_r & ~clr_high) | set_high;
            low_flag_r <= (low_flag_r & ~clr_low) | set_low;
        end
    end

    // power control and reference select registers
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            auto_standby_r <= 1'b0;
            auto_pd_r <= 1'b0;
            dly_r <= arpc_pkg::DLY_RESET;
            ref_force_r <= 1'b0;
            force_a_r <= 1'b0;
            force_b_r <= 1'b0;
            upper_ref_r <= 1'b0;
            lower_ref_r <= 1'b0;
        end else begin
            if (reg_wr_in && reg_addr_in == arpc_pkg::POWER_ADDR) begin
                auto_standby_r <= reg_wdata_in[arpc_pkg::AUTO_STANDBY_BIT];
                auto_pd_r <= reg_wdata_in[arpc_pkg::AUTO_PD_BIT];
                dly_r <= reg_wdata_in[arpc_pkg::DLY_MSB:arpc_pkg::DLY_LSB];
                ref_force_r <= reg_wdata_in[arpc_pkg::REF_FORCE_BIT];
                force_a_r <= reg_wdata_in[arpc_pkg::CONV_A_FORCE_BIT];
                force_b_r <= reg_wdata_in[arpc_pkg::CONV_B_FORCE_BIT];
            end
            if (reg_wr_in && reg_addr_in == arpc_pkg::REFSEL_ADDR) begin
                upper_ref_r <= reg_wdata_in[arpc_pkg::UPPER_REF_BIT];
                lower_ref_r <= reg_wdata_in[arpc_pkg::LOWER_REF_BIT];
            end
        end
    end

    // idle / wake / run sequencer
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r <= arpc_pkg::ARPC_IDLE;
            wake_cnt_r <= 6'h00;
            lp_pd_r <= 1'b0;
            lp_sb_r <= 1'b0;
            need_a_r <= 1'b0;
            need_b_r <= 1'b0;
        end else begin
            case (state_r)
                arpc_pkg::ARPC_IDLE: begin
                    // mode bits only sampled while idle
                    lp_pd_r <= auto_pd_r;
                    lp_sb_r <= auto_standby_r && !auto_pd_r;
                    need_a_r <= scan_req_a_in;
                    need_b_r <= scan_req_b_in;
                    if (scan_req_a_in || scan_req_b_in) begin
                        wake_cnt_r <= dly_r;
                        if ((auto_pd_r || auto_standby_r) && dly_r != 6'h00)
                        begin
                            state_r <= arpc_pkg::ARPC_WAKE;
                        end else begin
                            state_r <= arpc_pkg::ARPC_RUN;
                        end
                    end
                end
                arpc_pkg::ARPC_WAKE: begin
                    need_a_r <= need_a_r || scan_req_a_in;
                    need_b_r <= need_b_r || scan_req_b_in;
                    wake_cnt_r <= wake_cnt_r - 6'h01;
                    if (wake_cnt_r == 6'h01) begin
                        state_r <= arpc_pkg::ARPC_RUN;
                    end
                end
                arpc_pkg::ARPC_RUN: begin
                    need_a_r <= need_a_r || scan_req_a_in || scan_busy_a_in;
                    need_b_r <= need_b_r || scan_req_b_in || scan_busy_b_in;
                    if (!scan_busy_a_in && !scan_busy_b_in &&
                        !scan_req_a_in && !scan_req_b_in) begin
                        state_r <= arpc_pkg::ARPC_IDLE;
                        need_a_r <= 1'b0;
                        need_b_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= arpc_pkg::ARPC_IDLE;
                end
            endcase
        end
    end

    // converter power, grants, current mode and clock source
    // results of a scan on an unpowered converter are left as they come
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            // force bits and auto power-down clear: converters start on
            on_a_r <= 1'b1;
            on_b_r <= 1'b1;
            scan_grant_a_out <= 1'b0;
            scan_grant_b_out <= 1'b0;
            standby_current_out <= 1'b0;
            standby_clk_sel_out <= 1'b0;
        end else begin
            if (auto_pd_r && lp_pd_r) begin
                on_a_r <= !force_a_r && state_r != arpc_pkg::ARPC_IDLE &&
                    need_a_r;
                on_b_r <= !force_b_r && state_r != arpc_pkg::ARPC_IDLE &&
                    need_b_r;
            end else begin
                on_a_r <= !force_a_r;
                on_b_r <= !force_b_r;
            end
            scan_grant_a_out <= state_r == arpc_pkg::ARPC_RUN && scan_req_a_in;
            scan_grant_b_out <= state_r == arpc_pkg::ARPC_RUN && scan_req_b_in;
            // one shared mode, on only while idle with auto standby set and auto power-down clear
            standby_current_out <= state_r == arpc_pkg::ARPC_IDLE &&
                auto_standby_r && !auto_pd_r && lp_sb_r;
            standby_clk_sel_out <= state_r == arpc_pkg::ARPC_IDLE &&
                auto_standby_r && !auto_pd_r && lp_sb_r;
        end
    end

    assign conv_a_power_out = on_a_r;
    assign conv_b_power_out = on_b_r;

    // off status flags
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            off_a_r <= 1'b0;
            off_b_r <= 1'b0;
            stat_cnt_a_r <= 6'h00;
            stat_cnt_b_r <= 6'h00;
            force_a_d_r <= 1'b0;
            force_b_d_r <= 1'b0;
            ref_power_out <= 1'b1;
        end else begin
            force_a_d_r <= force_a_r;
            force_b_d_r <= force_b_r;
            if (force_a_r) begin
                off_a_r <= 1'b1;
                stat_cnt_a_r <= 6'h00;
            end else if (auto_pd_r) begin
                off_a_r <= !on_a_r;
            end else if (force_a_d_r) begin
                stat_cnt_a_r <= dly_r;
                off_a_r <= dly_r != 6'h00;
            end else if (stat_cnt_a_r != 6'h00) begin
                stat_cnt_a_r <= stat_cnt_a_r - 6'h01;
                off_a_r <= stat_cnt_a_r != 6'h01;
            end else begin
                off_a_r <= 1'b0;
            end
            if (force_b_r) begin
                off_b_r <= 1'b1;
                stat_cnt_b_r <= 6'h00;
            end else if (auto_pd_r) begin
                off_b_r <= !on_b_r;
            end else if (force_b_d_r) begin
                stat_cnt_b_r <= dly_r;
                off_b_r <= dly_r != 6'h00;
            end else if (stat_cnt_b_r != 6'h00) begin
                stat_cnt_b_r <= stat_cnt_b_r - 6'h01;
                off_b_r <= stat_cnt_b_r != 6'h01;
            end else begin
                off_b_r <= 1'b0;
            end
            // reference follows the converters in either force setting
            ref_power_out <= on_a_r || on_b_r;
        end
    end

    assign power_word = {auto_standby_r, 2'h0, !ref_power_out,
        off_b_r, off_a_r, dly_r, auto_pd_r, ref_force_r,
        force_b_r, force_a_r};

    // read mux, data one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd_in) begin
            if (hit(reg_addr_in, arpc_pkg::RESULT_BASE)) begin
                rdata_nxt = result_r[rslot];
            end else if (hit(reg_addr_in, arpc_pkg::LOW_BASE)) begin
                rdata_nxt = {1'b0,
                    low_r[slot_of(reg_addr_in, arpc_pkg::LOW_BASE)], 3'h0};
            end else if (hit(reg_addr_in, arpc_pkg::HIGH_BASE)) begin
                rdata_nxt = {1'b0,
                    high_r[slot_of(reg_addr_in, arpc_pkg::HIGH_BASE)], 3'h0};
            end else if (hit(reg_addr_in, arpc_pkg::OFFSET_BASE)) begin
                rdata_nxt = {1'b0,
                    offset_r[slot_of(reg_addr_in, arpc_pkg::OFFSET_BASE)],
                    3'h0};
            end else begin
                case (reg_addr_in)
                    arpc_pkg::POWER_ADDR: rdata_nxt = power_word;
                    arpc_pkg::REFSEL_ADDR:
                        rdata_nxt = {upper_ref_r, lower_ref_r, 14'h0000};
                    arpc_pkg::LIMIT_STAT_ADDR:
                        rdata_nxt = {high_flag_r, low_flag_r};
                    arpc_pkg::READY_STAT_ADDR: rdata_nxt = {8'h00, ready_r};
                    default: rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
            upper_ref_source_out <= 1'b0;
            lower_ref_source_out <= 1'b0;
            sample_ready_flag_out <= 8'h00;
            high_exceed_flag_out <= 8'h00;
            low_exceed_flag_out <= 8'h00;
        end else begin
            reg_rdata_out <= rdata_nxt;
            upper_ref_source_out <= upper_ref_r;
            lower_ref_source_out <= lower_ref_r;
            sample_ready_flag_out <= (ready_r & ~clr_ready) | set_ready;
            high_exceed_flag_out <= (high_flag_r & ~clr_high) | set_high;
            low_exceed_flag_out <= (low_flag_r & ~clr_low) | set_low;
        end
    end
endmodule

// ==== hdl/arpc_pkg.sv ====
// arpc_pkg: register map, field layout, reset values and power states
// for the converter result and power control block.
// assumes a 24-bit register address and 16-bit registers.
package arpc_pkg;
    localparam int ADDR_W = 24;
    localparam int SLOTS = 8;
    localparam int VAL_W = 12;
    localparam int DLY_W = 6;

    // register addresses
    localparam logic [23:0] RESULT_BASE = 24'h190030;
    localparam logic [23:0] LOW_BASE = 24'h190040;
    localparam logic [23:0] POWER_ADDR = 24'h190052;
    localparam logic [23:0] REFSEL_ADDR = 24'h190054;
    localparam logic [23:0] LIMIT_STAT_ADDR = 24'h190056;
    localparam logic [23:0] READY_STAT_ADDR = 24'h190058;
    localparam logic [23:0] HIGH_BASE = 24'h190060;
    localparam logic [23:0] OFFSET_BASE = 24'h190070;
    localparam logic [23:0] SLOT_STRIDE = 24'h000002;

    // value field position inside result, limit and offset registers
    localparam int VAL_LSB = 3;
    localparam int VAL_MSB = 14;
    localparam int SIGN_BIT = 15;

    // power control field positions
    localparam int AUTO_STANDBY_BIT = 15;
    localparam int REF_OFF_BIT = 12;
    localparam int CONV_B_OFF_BIT = 11;
    localparam int CONV_A_OFF_BIT = 10;
    localparam int DLY_LSB = 4;
    localparam int DLY_MSB = 9;
    localparam int AUTO_PD_BIT = 3;
    localparam int REF_FORCE_BIT = 2;
    localparam int CONV_B_FORCE_BIT = 1;
    localparam int CONV_A_FORCE_BIT = 0;

    // reference select field positions
    localparam int UPPER_REF_BIT = 15;
    localparam int LOWER_REF_BIT = 14;

    // reset values
    localparam logic [5:0] DLY_RESET = 6'h0d;
    localparam logic [11:0] HIGH_RESET = 12'hfff;
    localparam logic [11:0] LOW_RESET = 12'h000;
    localparam logic [11:0] OFFSET_RESET = 12'h000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ARPC_IDLE,
        ARPC_WAKE,
        ARPC_RUN
    } arpc_pstate_t;
endpackage

// ==== tb/arpc_top_properties.sv ====
// arpc_top_properties: port-level timing checks of the result and power block
// assumes it is bound to arpc_top and sees only that module's ports
`timescale 1ns/10ps
module arpc_top_properties (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [23:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic scan_req_a_in,
    input wire logic done_a_in,
    input wire logic [2:0] slot_a_in,
    input wire logic scan_grant_a_out,
    input wire logic scan_grant_b_out,
    input wire logic conv_a_power_out,
    input wire logic conv_b_power_out,
    input wire logic ref_power_out,
    input wire logic standby_current_out,
    input wire logic standby_clk_sel_out,
    input wire logic [7:0] sample_ready_flag_out,
    input wire logic [7:0] high_exceed_flag_out,
    input wire logic [7:0] low_exceed_flag_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic pwr_wr, lim_wr, res_rd;
    assign pwr_wr = reg_wr_in && reg_addr_in == arpc_pkg::POWER_ADDR;
    assign lim_wr = reg_wr_in && reg_addr_in == arpc_pkg::LIMIT_STAT_ADDR;
    assign res_rd = reg_rd_in && reg_addr_in[23:4] == 20'h19003 &&
                    !reg_addr_in[0];
    sequence s_a_start;
        $rose(scan_req_a_in) && !scan_grant_b_out;
    endsequence
    sequence s_a_granted;
        !scan_grant_a_out ##[1:65] scan_grant_a_out;
    endsequence
    AST_READY_SET: assert property (done_a_in |=>
        sample_ready_flag_out[$past(slot_a_in)]) else $error("ready not set");
    AST_READY_CLR: assert property (res_rd && !done_a_in |=>
        !sample_ready_flag_out[$past(reg_addr_in[3:1])])
        else $error("ready not cleared by read");
    AST_HIGH_STICKY: assert property (!lim_wr |=>
        (high_exceed_flag_out & $past(high_exceed_flag_out)) ==
        $past(high_exceed_flag_out)) else $error("high flag lost");
    AST_LOW_STICKY: assert property (!lim_wr |=>
        (low_exceed_flag_out & $past(low_exceed_flag_out)) ==
        $past(low_exceed_flag_out)) else $error("low flag lost");
    AST_GRANT_DELAY: assert property (s_a_start |=> s_a_granted)
        else $error("grant timing wrong");
    AST_GRANT_REQ: assert property (scan_grant_a_out |->
        $past(scan_req_a_in)) else $error("grant without request");
    AST_REF_ON: assert property (conv_a_power_out || conv_b_power_out
        |=> ref_power_out) else $error("reference not on");
    AST_FORCE_A: assert property (pwr_wr && reg_wdata_in[0] |->
        ##[1:2] !conv_a_power_out) else $error("force off ignored");
    AST_STANDBY_IDLE: assert property (standby_current_out |->
        !scan_grant_a_out && !scan_grant_b_out && standby_clk_sel_out)
        else $error("standby while scanning");
endmodule
bind arpc_top arpc_top_properties u_props (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .scan_req_a_in(scan_req_a_in),
    .done_a_in(done_a_in), .slot_a_in(slot_a_in),
    .scan_grant_a_out(scan_grant_a_out), .scan_grant_b_out(scan_grant_b_out),
    .conv_a_power_out(conv_a_power_out), .conv_b_power_out(conv_b_power_out),
    .ref_power_out(ref_power_out), .standby_current_out(standby_current_out),
    .standby_clk_sel_out(standby_clk_sel_out),
    .sample_ready_flag_out(sample_ready_flag_out),
    .high_exceed_flag_out(high_exceed_flag_out),
    .low_exceed_flag_out(low_exceed_flag_out));

// ==== tb/arpc_conv_model.sv ====
// arpc_conv_model: behavioural converter core, one sample per scan
// assumes grant is sampled on the rising clock edge
`timescale 1ns/10ps
module arpc_conv_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [2:0] slot_in,
    input wire logic [11:0] raw_in,
    input wire logic grant_in,
    output logic req_out,
    output logic busy_out,
    output logic done_out,
    output logic [2:0] slot_out,
    output logic [11:0] raw_out
);
    initial begin
        int n;
        {req_out, busy_out, done_out, slot_out, raw_out} = '0;
        forever begin
            @(posedge clk_in);
            if (go_in) begin
                req_out <= 1'b1;
                n = 0;
                do begin
                    @(posedge clk_in);
                    n++;
                end while (!grant_in && n < 200);
                req_out <= 1'b0;
                busy_out <= 1'b1;
                @(posedge clk_in) done_out <= 1'b1;
                slot_out <= slot_in;
                raw_out <= raw_in;
                @(posedge clk_in) done_out <= 1'b0;
                raw_out <= ~raw_in;
                busy_out <= 1'b0;
            end
        end
    end
endmodule

// ==== tb/tb_adc_result_and_power_control.sv ====
// tb_adc_result_and_power_control: directed scenarios for arpc_top
// assumes two arpc_conv_model lanes stand in for the converter cores
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_adc_result_and_power_control;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, go_a = 0, go_b = 0, seen, sbl;
    logic [23:0] addr = '0;
    logic [15:0] wdata = '0, rdata;
    logic [2:0] sl_a = '0, sl_b = '0, slot_a, slot_b;
    logic [11:0] rw_a = '0, rw_b = '0, raw_a, raw_b;
    logic req_a, req_b, busy_a, busy_b, done_a, done_b, gnt_a, gnt_b;
    logic pw_a, pw_b, pw_r, sb_cur, sb_clk, up_r, lo_r;
    logic [7:0] rdy, hi_f, lo_f;
    int err_total = 0, num_checks = 0;
    initial forever #2 clk = ~clk;
    arpc_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .scan_req_a_in(req_a), .scan_req_b_in(req_b),
        .scan_busy_a_in(busy_a), .scan_busy_b_in(busy_b),
        .done_a_in(done_a), .slot_a_in(slot_a), .raw_a_in(raw_a),
        .done_b_in(done_b), .slot_b_in(slot_b), .raw_b_in(raw_b),
        .scan_grant_a_out(gnt_a), .scan_grant_b_out(gnt_b),
        .conv_a_power_out(pw_a), .conv_b_power_out(pw_b),
        .ref_power_out(pw_r), .standby_current_out(sb_cur),
        .standby_clk_sel_out(sb_clk), .upper_ref_source_out(up_r),
        .lower_ref_source_out(lo_r), .sample_ready_flag_out(rdy),
        .high_exceed_flag_out(hi_f), .low_exceed_flag_out(lo_f));
    arpc_conv_model lane_a (.clk_in(clk), .go_in(go_a), .slot_in(sl_a),
        .raw_in(rw_a), .grant_in(gnt_a), .req_out(req_a), .busy_out(busy_a),
        .done_out(done_a), .slot_out(slot_a), .raw_out(raw_a));
    arpc_conv_model lane_b (.clk_in(clk), .go_in(go_b), .slot_in(sl_b),
        .raw_in(rw_b), .grant_in(gnt_b), .req_out(req_b), .busy_out(busy_b),
        .done_out(done_b), .slot_out(slot_b), .raw_out(raw_b));
    task automatic wr_reg(input logic [23:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [23:0] a, input logic [15:0] e,
                          input logic [15:0] m = 16'hffff);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 `CHK(rdata & m, e)
    endtask
    task automatic scan(input logic ea, eb, input logic [2:0] sa, sb,
                        input logic [11:0] ra, rb);
        int n;
        @(posedge clk);
        {go_a, go_b, sl_a, sl_b, rw_a, rw_b} <= {ea, eb, sa, sb, ra, rb};
        @(posedge clk) {go_a, go_b} <= 2'b00;
        {seen, sbl, n} = '0;
        do begin
            @(negedge clk);
            seen |= pw_a;
            sbl |= !sb_cur;
            n++;
        end while ((req_a || busy_a || req_b || busy_b || n < 3) && n < 300);
        repeat (4) @(negedge clk);
    endtask
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(arpc_pkg::POWER_ADDR, 16'h00d0);
        rd_chk(arpc_pkg::HIGH_BASE, 16'h7ff8);
        rd_chk(arpc_pkg::LOW_BASE + 24'he, 16'h0000);
        rd_chk(arpc_pkg::RESULT_BASE + 24'h1, 16'h0000);
        wr_reg(arpc_pkg::OFFSET_BASE + 24'h4, 16'h0400);
        wr_reg(arpc_pkg::OFFSET_BASE + 24'h6, 16'h1000);
        wr_reg(arpc_pkg::OFFSET_BASE + 24'h2, 16'h0080);
        wr_reg(arpc_pkg::HIGH_BASE + 24'h6, 16'h0780);
        wr_reg(arpc_pkg::LOW_BASE + 24'ha, 16'h0808);
        wr_reg(arpc_pkg::POWER_ADDR, 16'h0048);
        repeat (4) @(negedge clk);
        `CHK({pw_a, pw_b}, 2'b00)
        scan(1, 1, 3'd2, 3'd5, 12'h100, 12'h100);
        `CHK({seen, pw_a}, 2'b10)
        `CHK(lo_f, 8'h20)
        scan(1, 0, 3'd3, 3'd0, 12'h100, 12'h000);
        `CHK(hi_f, 8'h08)
        `CHK(rdy, 8'h2c)
        rd_chk(arpc_pkg::LIMIT_STAT_ADDR, 16'h0820);
        rd_chk(arpc_pkg::RESULT_BASE + 24'h4, 16'h0400);
        rd_chk(arpc_pkg::RESULT_BASE + 24'h6, 16'hf800);
        rd_chk(arpc_pkg::RESULT_BASE + 24'ha, 16'h0800);
        `CHK(rdy, 8'h00)
        wr_reg(arpc_pkg::LIMIT_STAT_ADDR, 16'h0800);
        rd_chk(arpc_pkg::LIMIT_STAT_ADDR, 16'h0020);
        wr_reg(arpc_pkg::LIMIT_STAT_ADDR, 16'h0020);
        scan(1, 1, 3'd3, 3'd5, 12'h0f0, 12'h101);
        `CHK({hi_f, lo_f}, 16'h0000)
        wr_reg(arpc_pkg::RESULT_BASE + 24'h2, 16'hffff);
        rd_chk(arpc_pkg::RESULT_BASE + 24'h2, 16'h7f78);
        wr_reg(arpc_pkg::POWER_ADDR, 16'h0053);
        repeat (3) @(negedge clk);
        `CHK({pw_a, pw_b, pw_r}, 3'b000)
        rd_chk(arpc_pkg::POWER_ADDR, 16'h1c53);
        wr_reg(arpc_pkg::POWER_ADDR, 16'h0050);
        rd_chk(arpc_pkg::POWER_ADDR, 16'h0c00, 16'h0c00);
        repeat (10) @(negedge clk);
        rd_chk(arpc_pkg::POWER_ADDR, 16'h0050);
        `CHK({pw_a, pw_b, pw_r}, 3'b111)
        wr_reg(arpc_pkg::POWER_ADDR, 16'h8050);
        repeat (3) @(negedge clk);
        `CHK({sb_cur, sb_clk}, 2'b11)
        scan(1, 0, 3'd0, 3'd0, 12'h010, 12'h000);
        `CHK({sbl, sb_cur}, 2'b11)
        wr_reg(arpc_pkg::POWER_ADDR, 16'h8058);
        repeat (3) @(negedge clk);
        `CHK(sb_cur, 1'b0)
        wr_reg(arpc_pkg::REFSEL_ADDR, 16'hc000);
        rd_chk(arpc_pkg::REFSEL_ADDR, 16'hc000);
        `CHK({up_r, lo_r}, 2'b11)
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule
